// ===== logic/tmrx_cfg.svh
// Purpose: Constants for the timer external-input block
// Assumes: 100 MHz clk, active-low async reset
// Notes: Summary of operation below
//
// Summary of operation
// - Gate-select 1 set: ext_irq1_pin level also gates timer 1 run.
// - Type 1 set: falling edge on ext_irq1_pin sets ext_irq1_flag.
// - Type 1 clear: low level on ext_irq1_pin sets ext_irq1_flag.
// - Timer 0 as counter: count pin falling edge increments timer 0.
// - Timer 1 as counter: count pin falling edge increments timer 1.
// - Gate-select 0 set: ext_irq0_pin level also gates timer 0 run.
// - Type 0 set: falling edge on ext_irq0_pin sets ext_irq0_flag.
// - Type 0 clear: low level on ext_irq0_pin sets ext_irq0_flag.
`ifndef TMRX_CFG_SVH
`define TMRX_CFG_SVH

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define TMRX_CNT_W 16
`define TMRX_NPIN 4
`define TMRX_CNT_RST 16'h0000
`define TMRX_PIN_RST 4'hf

// ----------------------------------------
// Pin index within the synchroniser vector
// ----------------------------------------
`define TMRX_IDX_IRQ0 0
`define TMRX_IDX_IRQ1 1
`define TMRX_IDX_CNT0 2
`define TMRX_IDX_CNT1 3

`endif

// ===== logic/tmrx_pkg.sv
// Purpose: Types for the timer external-input block
// Assumes: Included after tmrx_cfg.svh
// Notes: Per-timer control travels as one packed struct
package tmrx_pkg;

  typedef struct packed {
    logic run;
    logic gate_select;
    logic counter_mode;
    logic irq_type;
    logic flag_clear;
  } tmrx_ctl_t;

endpackage

// ===== logic/tmrx_top.sv
// Purpose: External pin logic for two 16-bit timers and two external interrupts
// Assumes: Pins asynchronous to clk; control bits come from clk-domain logic
// Notes: Timer mode (not counter) advances once per clk while running
`timescale 1ns/100ps
`include "tmrx_cfg.svh"

module tmrx_top
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  input wire tmrx_pkg::tmrx_ctl_t timer0_ctl,
  input wire tmrx_pkg::tmrx_ctl_t timer1_ctl,
  output logic [`TMRX_CNT_W-1:0] timer0_count,
  output logic [`TMRX_CNT_W-1:0] timer1_count,
  output logic timer0_overflow,
  output logic timer1_overflow,
  output logic ext_irq0_flag,
  output logic ext_irq1_flag
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Stage a is metastability-only; b and c agree before a change counts
  logic [`TMRX_NPIN-1:0] pin_raw;
  logic [`TMRX_NPIN-1:0] sync_a_ff;
  logic [`TMRX_NPIN-1:0] sync_b_ff;
  logic [`TMRX_NPIN-1:0] sync_c_ff;
  logic [`TMRX_NPIN-1:0] pin_lvl_ff;
  logic [`TMRX_NPIN-1:0] nxt_sync_a;
  logic [`TMRX_NPIN-1:0] nxt_sync_b;
  logic [`TMRX_NPIN-1:0] nxt_sync_c;
  logic [`TMRX_NPIN-1:0] nxt_pin_lvl;
  logic [`TMRX_NPIN-1:0] pin_fall;

  assign pin_raw = {timer1_count_pin, timer0_count_pin, ext_irq1_pin, ext_irq0_pin};

  always_comb
  begin
    nxt_sync_a = pin_raw;
    nxt_sync_b = sync_a_ff;
    nxt_sync_c = sync_b_ff;
    nxt_pin_lvl = pin_lvl_ff;
    pin_fall = '0;
    for (int i = 0; i < `TMRX_NPIN; i++)
    begin
      if (sync_b_ff[i] == sync_c_ff[i])
      begin
        nxt_pin_lvl[i] = sync_c_ff[i];
        pin_fall[i] = pin_lvl_ff[i] & ~sync_c_ff[i];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_a_ff <= `TMRX_PIN_RST;
      sync_b_ff <= `TMRX_PIN_RST;
      sync_c_ff <= `TMRX_PIN_RST;
      pin_lvl_ff <= `TMRX_PIN_RST;
    end
    else
    begin
      sync_a_ff <= nxt_sync_a;
      sync_b_ff <= nxt_sync_b;
      sync_c_ff <= nxt_sync_c;
      pin_lvl_ff <= nxt_pin_lvl;
    end
  end

  // ----------------------------------------
  // Timers and interrupt flags
  // ----------------------------------------
  logic [1:0][`TMRX_CNT_W-1:0] cnt_ff;
  logic [1:0][`TMRX_CNT_W-1:0] nxt_cnt;
  logic [1:0] ovf_ff;
  logic [1:0] nxt_ovf;
  logic [1:0] flag_ff;
  logic [1:0] nxt_flag;
  logic [1:0] run_en;
  logic [1:0] tick;
  logic [1:0] irq_set;
  tmrx_pkg::tmrx_ctl_t ctl [2];

  assign ctl[0] = timer0_ctl;
  assign ctl[1] = timer1_ctl;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_tmr
      // Gate pin is the interrupt pin of the same index
      assign run_en[g] = ctl[g].run & (~ctl[g].gate_select | pin_lvl_ff[g]);
      assign tick[g] = run_en[g] & (ctl[g].counter_mode ? pin_fall[g+2] : 1'b1);
      // Edge or level detect
      assign irq_set[g] = ctl[g].irq_type ? pin_fall[g] : ~pin_lvl_ff[g];
    end
  endgenerate

  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_ovf = '0;
    nxt_flag = flag_ff;
    for (int i = 0; i < 2; i++)
    begin
      if (tick[i])
      begin
        nxt_cnt[i] = cnt_ff[i] + `TMRX_CNT_W'(1);
        nxt_ovf[i] = &cnt_ff[i];
      end
      // Set wins over clear so a coincident event is not lost
      if (irq_set[i])
        nxt_flag[i] = 1'b1;
      else if (ctl[i].flag_clear)
        nxt_flag[i] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_ff <= {`TMRX_CNT_RST, `TMRX_CNT_RST};
      ovf_ff <= '0;
      flag_ff <= '0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      ovf_ff <= nxt_ovf;
      flag_ff <= nxt_flag;
    end
  end

  assign timer0_count = cnt_ff[0];
  assign timer1_count = cnt_ff[1];
  assign timer0_overflow = ovf_ff[0];
  assign timer1_overflow = ovf_ff[1];
  assign ext_irq0_flag = flag_ff[0];
  assign ext_irq1_flag = flag_ff[1];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_cnt1_fall;
    pin_lvl_ff[3] && sync_b_ff[3] == sync_c_ff[3] && !sync_c_ff[3];
  endsequence

  a_cnt1_edge_inc: assert property (
    (s_cnt1_fall and (timer1_ctl.run && timer1_ctl.counter_mode && !timer1_ctl.gate_select))
    |=> timer1_count == $past(timer1_count) + 16'h0001)
    else $error("timer 1 missed a count edge");
  a_cnt0_hold: assert property (
    (timer0_ctl.counter_mode && !pin_fall[2]) |=> timer0_count == $past(timer0_count))
    else $error("timer 0 counted without an edge");
  a_timer0_gate_select_block: assert property (
    (timer0_ctl.gate_select && !pin_lvl_ff[0]) |=> $stable(timer0_count))
    else $error("timer 0 ran with gate low");
  a_timer1_gate_select_block: assert property (
    (timer1_ctl.gate_select && !pin_lvl_ff[1]) |=> $stable(timer1_count))
    else $error("timer 1 ran with gate low");
  a_irq0_level: assert property (
    (!timer0_ctl.irq_type && !pin_lvl_ff[0]) |=> ext_irq0_flag)
    else $error("low level did not set flag 0");
  a_irq1_level: assert property (
    (!timer1_ctl.irq_type && !pin_lvl_ff[1]) |=> ext_irq1_flag)
    else $error("low level did not set flag 1");
  a_irq0_edge: assert property (
    (timer0_ctl.irq_type && $fell(pin_lvl_ff[0])) |-> ext_irq0_flag)
    else $error("falling edge did not set flag 0");
  a_irq1_edge: assert property (
    (timer1_ctl.irq_type && $fell(pin_lvl_ff[1])) |-> ext_irq1_flag)
    else $error("falling edge did not set flag 1");
  a_sync_delay: assert property (
    $fell(ext_irq0_pin) ##1 !ext_irq0_pin [*3] |=> !pin_lvl_ff[0])
    else $error("synchroniser too slow");

  sequence s_cnt0_low2;
    $fell(timer0_count_pin) ##1 !timer0_count_pin;
  endsequence

  // Count pins may stay low only a few clk, so two low samples must already count
  a_sync_cnt0: assert property (
    s_cnt0_low2 |-> ##3 !pin_lvl_ff[2])
    else $error("count pin 0 synchroniser too slow");
  a_cnt0_edge_inc: assert property (
    (pin_fall[2] && timer0_ctl.run && timer0_ctl.counter_mode && !timer0_ctl.gate_select)
    |=> timer0_count == $past(timer0_count) + 16'h0001)
    else $error("timer 0 missed a count edge");
  a_run0_hold: assert property (
    !timer0_ctl.run |=> $stable(timer0_count))
    else $error("timer 0 ran while stopped");
  a_tmr1_free_run: assert property (
    (timer1_ctl.run && !timer1_ctl.counter_mode && (!timer1_ctl.gate_select || pin_lvl_ff[1]))
    |=> timer1_count == $past(timer1_count) + 16'h0001)
    else $error("timer 1 missed a clk in timer mode");
  a_flag0_clear: assert property (
    (timer0_ctl.flag_clear && !irq_set[0]) |=> !ext_irq0_flag)
    else $error("flag 0 not cleared");
  a_flag1_clear: assert property (
    (timer1_ctl.flag_clear && !irq_set[1]) |=> !ext_irq1_flag)
    else $error("flag 1 not cleared");
  a_ovf0_wrap: assert property (
    (tick[0] && &cnt_ff[0]) |=> timer0_overflow)
    else $error("timer 0 wrap gave no overflow pulse");
  a_ovf0_quiet: assert property (
    !(tick[0] && &cnt_ff[0]) |=> !timer0_overflow)
    else $error("timer 0 overflow without a wrap");
  a_ovf1_wrap: assert property (
    (tick[1] && &cnt_ff[1]) |=> timer1_overflow)
    else $error("timer 1 wrap gave no overflow pulse");
  a_ovf1_quiet: assert property (
    !(tick[1] && &cnt_ff[1]) |=> !timer1_overflow)
    else $error("timer 1 overflow without a wrap");

endmodule

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the timer external-input block
// Assumes: Inputs change at the falling edge of clk
// Notes: The timer-mode wrap of timer 1 takes about 65k clk of the run
`timescale 1ns/100ps

module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] fire = 4'h0;
  logic [3:0] hold = 4'h0;
  logic [3:0] pin;
  tmrx_pkg::tmrx_ctl_t c0 = '0;
  tmrx_pkg::tmrx_ctl_t c1 = '0;
  logic [15:0] q0, q1, e0, e1;
  logic f0, f1, o0, o1;
  int n_mismatch = 0;
  int compares = 0;
  int seed = 32'h56cb0c73;
  int n;

  tmrx_src tmrx_src_i(.clk(clk), .reset_n(reset_n), .fire(fire), .hold(hold), .pin(pin));
  tmrx_top tmrx_top_i(.clk(clk), .reset_n(reset_n), .ext_irq0_pin(pin[0]),
    .ext_irq1_pin(pin[1]), .timer0_count_pin(pin[2]), .timer1_count_pin(pin[3]),
    .timer0_ctl(c0), .timer1_ctl(c1), .timer0_count(q0), .timer1_count(q1),
    .timer0_overflow(o0), .timer1_overflow(o1), .ext_irq0_flag(f0), .ext_irq1_flag(f1));

  initial
  begin
    forever #5 clk = !clk;
  end

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [15:0] exp_count(logic [15:0] prev, logic hit);
    return prev + {15'h0000, hit};
  endfunction

  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic pulse(logic [3:0] m);
    fire = m;
    cyc(1);
    fire = 4'h0;
    cyc(8);
  endtask

  task automatic clr();
    c0.flag_clear = 1'b1;
    c1.flag_clear = 1'b1;
    cyc(1);
    c0.flag_clear = 1'b0;
    c1.flag_clear = 1'b0;
    cyc(2);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #700000;
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    cyc(2);
    reset_n = 1'b1;
    c0.run = 1'b1;
    c0.counter_mode = 1'b1;
    c1 = c0;
    e0 = 16'h0000;
    e1 = 16'h0000;
    cyc(4);
    chk("flags idle", {14'h0000, f1, f0}, 16'h0000);
    // Random events on the count pins, some on both in the same clk, some on one side only
    repeat (8)
    begin
      n = $random(seed);
      pulse({n[1:0], 2'b00});
      e0 = exp_count(e0, n[0]);
      e1 = exp_count(e1, n[1]);
      chk("count0", q0, e0);
      chk("count1", q1, e1);
    end
    // Gate closed by low irq pins, which also raise level flags
    c0.gate_select = 1'b1;
    c1.gate_select = 1'b1;
    hold = 4'h3;
    cyc(5);
    pulse(4'hc);
    chk("gated count0", q0, e0);
    chk("gated count1", q1, e1);
    clr();
    chk("level flags", {14'h0000, f1, f0}, 16'h0003);
    hold = 4'h0;
    cyc(5);
    pulse(4'hc);
    e0 = exp_count(e0, 1'b1);
    e1 = exp_count(e1, 1'b1);
    chk("open count0", q0, e0);
    chk("open count1", q1, e1);
    clr();
    chk("flags cleared", {14'h0000, f1, f0}, 16'h0000);
    // Edge mode: one fall sets once, a held low level does not re-set
    c0.irq_type = 1'b1;
    c1.irq_type = 1'b1;
    hold = 4'h3;
    cyc(6);
    chk("edge flags", {14'h0000, f1, f0}, 16'h0003);
    clr();
    chk("edge held low", {14'h0000, f1, f0}, 16'h0000);
    // Timer mode: one count per clk while run is set and the gate pin is high
    hold = 4'h0;
    c0.run = 1'b0;
    c1.run = 1'b0;
    c0.counter_mode = 1'b0;
    c1.counter_mode = 1'b0;
    cyc(6);
    chk("stopped count0", q0, e0);
    chk("stopped count1", q1, e1);
    n = ($random(seed) & 32'hff) + 1;
    c0.run = 1'b1;
    c1.run = 1'b1;
    cyc(n);
    c0.run = 1'b0;
    e0 = e0 + n[15:0];
    e1 = e1 + n[15:0];
    chk("timed count0", q0, e0);
    chk("timed count1", q1, e1);
    // Timer 1 runs on alone to the wrap, which must pulse its overflow once
    n = 32'h10000 - e1;
    cyc(n);
    c1.run = 1'b0;
    chk("wrap count1", q1, 16'h0000);
    chk("overflow1 pulse", {15'h0000, o1}, 16'h0001);
    cyc(1);
    chk("overflow1 ends", {15'h0000, o1}, 16'h0000);
    chk("overflow0 quiet", {15'h0000, o0}, 16'h0000);
    give_verdict();
  end
endmodule

// ===== testbench/tmrx_src.sv
// Purpose: Event source model for the four external pins
// Assumes: Pins have pull-ups, so a released pin idles high
// Notes: Each fire gives 3 clk low then 3 clk high, enough to count once
`timescale 1ns/100ps

module tmrx_src
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] fire,
  input wire logic [3:0] hold,
  output logic [3:0] pin
);
  logic [2:0] cnt_ff [4];

  always_ff @(posedge clk or negedge reset_n)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!reset_n)
        cnt_ff[i] <= 3'h0;
      else if (fire[i] && cnt_ff[i] == 3'h0)
        cnt_ff[i] <= 3'h6;
      else if (cnt_ff[i] != 3'h0)
        cnt_ff[i] <= cnt_ff[i] - 3'h1;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      pin[i] = !(hold[i] || cnt_ff[i] > 3'h3);
  end
endmodule
